/* logic/ebcc_pkg.sv */
// Constants and carrier types for the expanded bank channel config block.
// Assumes a 100 MHz clock and a host port already in the clk domain.
package ebcc_pkg;
	localparam int CHANNELS = 8;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 5;
	localparam int IDX_W = 3;
	localparam int SLOTS = 8;
	localparam logic [ADDR_W-1:0] BANK_PTR_ADDR = 5'h1f;
	localparam logic [ADDR_W-1:0] SOFT_RST_ADDR = 5'h0a;
	localparam logic [ADDR_W-1:0] EXP_LAST_ADDR = 5'h07;
	localparam logic [DATA_W-1:0] BANK_PRIMARY = 8'h00;
	localparam logic [DATA_W-1:0] BANK_EXPANDED = 8'haa;
	localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
	localparam logic [IDX_W-1:0] OFS_SINGLE_RAIL = 3'h0;
	localparam logic [IDX_W-1:0] OFS_LINE_CODE = 3'h1;
	localparam logic [IDX_W-1:0] OFS_RECOVERY = 3'h2;
	localparam logic [IDX_W-1:0] OFS_RX_SLEEP = 3'h3;
	localparam logic [IDX_W-1:0] OFS_TX_SLEEP = 3'h4;
	localparam logic [IDX_W-1:0] OFS_ZERO_RUN = 3'h5;
	localparam logic [IDX_W-1:0] OFS_VIOLATION = 3'h6;
	localparam logic [IDX_W-1:0] OFS_EQUALIZER = 3'h7;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SOFT_RST_NS = 1000;
	localparam int SOFT_RST_CYCLES = (SOFT_RST_NS / CLK_PERIOD_NS < 1) ? 1 :
		SOFT_RST_NS / CLK_PERIOD_NS;
	localparam int TX_CLK_LOW_NS = 640;
	localparam int TX_CLK_LOW_CYCLES = (TX_CLK_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
	localparam logic [CNT_W-1:0] SOFT_RST_LAST = CNT_W'(SOFT_RST_CYCLES - 1);
	localparam logic [CNT_W-1:0] TX_LOW_LAST = CNT_W'(TX_CLK_LOW_CYCLES - 1);

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} ebcc_host_req_type;

	typedef struct packed {
		logic [CHANNELS-1:0] singleRail;
		logic [CHANNELS-1:0] amiCode;
		logic [CHANNELS-1:0] recoveryOff;
		logic [CHANNELS-1:0] rxSleep;
		logic [CHANNELS-1:0] txSleep;
		logic [CHANNELS-1:0] zeroDetect;
		logic [CHANNELS-1:0] violationDetect;
		logic [CHANNELS-1:0] equalizer;
	} ebcc_chan_cfg_type;

	typedef enum logic {
		EBCC_RUN,
		EBCC_SOFT_RESET
	} ebcc_state_type;
endpackage

/* logic/ebcc_reg_mem.sv */
// Eight-word store for the expanded register bank.
// Assumes the owner gates writes; clear wipes every word in one edge.
module ebcc_reg_mem (
	input wire logic clk,
	input wire logic nrst,
	input wire logic clear,
	input wire logic wrEn,
	input wire logic [ebcc_pkg::IDX_W-1:0] wrIdx,
	input wire logic [ebcc_pkg::DATA_W-1:0] wrData,
	input wire logic [ebcc_pkg::IDX_W-1:0] rdIdx,
	output logic [ebcc_pkg::DATA_W-1:0] rdData_q,
	output logic [ebcc_pkg::SLOTS-1:0][ebcc_pkg::DATA_W-1:0] words_q
);
	////////////////////////////////////////////////////////////////////////
	// Storage
	genvar gi;
	generate
		for (gi = 0; gi < ebcc_pkg::SLOTS; gi++) begin : gWord
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					words_q[gi] <= ebcc_pkg::REG_RESET;
				end else if (clear) begin
					words_q[gi] <= ebcc_pkg::REG_RESET;
				end else if (wrEn && wrIdx == ebcc_pkg::IDX_W'(gi)) begin
					words_q[gi] <= wrData;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Registered read port
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdData_q <= ebcc_pkg::REG_RESET;
		end else begin
			rdData_q <= words_q[rdIdx];
		end
	end
endmodule

/* logic/ebcc_expanded_bank.sv */
// Bank pointer and expanded per-channel line settings for eight channels.
// Assumes host requests and line pins arrive synchronous to clk.
//
// Summary of operation
// R1 - Read/write bank pointer lives at primary address 1f.
// R2 - Pointer value 00 selects the primary bank, and is the default.
// R3 - Software writes aa to the pointer; accesses then hit the expanded bank.
// R4 - At power-up the pointer selects the primary bank without host action.
// R5 - Single-rail bit 0 lets the pin choose; 1 forces single rail with recovery on.
// R6 - Line-code bit 0 picks HDB3, 1 AMI, when forced single rail with recovery.
// R7 - Recovery bit 0 keeps clock recovery on, 1 turns it off.
// R8 - Receiver sleep bit 1 powers that receiver down.
// R9 - Transmitter sleep bit 1 powers down the transmitter, driver high impedance.
// R10 - Transmit clock pin held low also powers down the transmitter.
// R11 - Zero-run bit 1 enables excessive-zero detect for single-rail HDB3.
// R12 - Violation bit 0 enables code-violation detect; 1 disables it. The code enables it only in single-rail HDB3.
// R13 - Equalizer bit 1 enables the receive equalizer for long lines.
// R14 - All expanded registers and the pointer reset to 00.
// R15 - Bit n of each expanded register drives channel n, bit 0 lowest.
// R16 - Pointer stays reachable at 1f while the expanded bank is selected.
// R17 - A write to the soft reset address starts a 1 us full reset. The code starts it only while the primary bank is selected.
module ebcc_expanded_bank (
	input wire logic clk,
	input wire logic nrst,
	input wire ebcc_pkg::ebcc_host_req_type hostReq,
	input wire logic [ebcc_pkg::CHANNELS-1:0] txNegRailPin,
	input wire logic [ebcc_pkg::CHANNELS-1:0] txClockPin,
	output logic [ebcc_pkg::DATA_W-1:0] hostRdData_q,
	output logic hostRdValid_q,
	output logic [ebcc_pkg::DATA_W-1:0] bankPointer_q,
	output logic expandedSel_q,
	output logic softResetBusy_q,
	output ebcc_pkg::ebcc_chan_cfg_type chanCfg_q
);
	////////////////////////////////////////////////////////////////////////
	// Decoding helpers
	function automatic logic isExpanded(input logic [ebcc_pkg::DATA_W-1:0] ptr);
		isExpanded = (ptr == ebcc_pkg::BANK_EXPANDED);
	endfunction

	function automatic logic hitsExpanded(input logic [ebcc_pkg::DATA_W-1:0] ptr,
			input logic [ebcc_pkg::ADDR_W-1:0] addr);
		hitsExpanded = isExpanded(ptr) && addr <= ebcc_pkg::EXP_LAST_ADDR;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Declarations
	ebcc_pkg::ebcc_state_type state_q;
	logic [ebcc_pkg::CNT_W-1:0] rstCnt_q;
	logic [ebcc_pkg::DATA_W-1:0] memRdData;
	logic [ebcc_pkg::SLOTS-1:0][ebcc_pkg::DATA_W-1:0] words;
	logic ptrHit;
	logic softRstHit;
	logic expHit;
	logic memWrEn;
	logic memClear;
	logic rdStage_q;
	logic rdFromMem_q;
	logic [ebcc_pkg::DATA_W-1:0] rdPtrVal_q;
	logic [ebcc_pkg::CHANNELS-1:0] txClkHeldLow_q;
	logic [ebcc_pkg::CHANNELS-1:0] forcedSingle;
	logic [ebcc_pkg::CHANNELS-1:0] singleRailMode;
	logic [ebcc_pkg::CHANNELS-1:0] amiMode;
	logic [ebcc_pkg::CNT_W-1:0] clearRun_q;

	////////////////////////////////////////////////////////////////////////
	// Address decode; the pointer answers in both banks
	assign ptrHit = hostReq.addr == ebcc_pkg::BANK_PTR_ADDR; // see R1 see R16
	assign expHit = hitsExpanded(bankPointer_q, hostReq.addr); // see R3
	assign softRstHit = !isExpanded(bankPointer_q) && hostReq.addr == ebcc_pkg::SOFT_RST_ADDR;
	assign memWrEn = hostReq.wr && expHit && state_q == ebcc_pkg::EBCC_RUN;
	assign memClear = state_q == ebcc_pkg::EBCC_SOFT_RESET; // see R17

	////////////////////////////////////////////////////////////////////////
	// Soft reset sequencer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ebcc_pkg::EBCC_RUN;
			rstCnt_q <= ebcc_pkg::CNT_ZERO;
		end else begin
			unique case (state_q)
				ebcc_pkg::EBCC_RUN: begin
					if (hostReq.wr && softRstHit) begin
						state_q <= ebcc_pkg::EBCC_SOFT_RESET; // see R17
						rstCnt_q <= ebcc_pkg::CNT_ZERO;
					end
				end
				ebcc_pkg::EBCC_SOFT_RESET: begin
					if (rstCnt_q == ebcc_pkg::SOFT_RST_LAST) begin
						state_q <= ebcc_pkg::EBCC_RUN;
					end else begin
						rstCnt_q <= rstCnt_q + ebcc_pkg::CNT_ONE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			softResetBusy_q <= 1'b0;
		end else begin
			softResetBusy_q <= (state_q == ebcc_pkg::EBCC_SOFT_RESET)
				? (rstCnt_q != ebcc_pkg::SOFT_RST_LAST) : (hostReq.wr && softRstHit);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bank pointer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bankPointer_q <= ebcc_pkg::BANK_PRIMARY; // see R2 see R4 see R14
		end else if (memClear) begin
			bankPointer_q <= ebcc_pkg::BANK_PRIMARY; // see R17
		end else if (hostReq.wr && ptrHit) begin
			bankPointer_q <= hostReq.data; // see R1 see R16
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			expandedSel_q <= 1'b0;
		end else if (memClear) begin
			expandedSel_q <= 1'b0;
		end else if (hostReq.wr && ptrHit) begin
			expandedSel_q <= isExpanded(hostReq.data); // see R3
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Expanded register store
	ebcc_reg_mem uMem (
		.clk(clk),
		.nrst(nrst),
		.clear(memClear),
		.wrEn(memWrEn),
		.wrIdx(hostReq.addr[ebcc_pkg::IDX_W-1:0]),
		.wrData(hostReq.data),
		.rdIdx(hostReq.addr[ebcc_pkg::IDX_W-1:0]),
		.rdData_q(memRdData),
		.words_q(words)
	);

	////////////////////////////////////////////////////////////////////////
	// Read path, two cycles; unmapped addresses read zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdStage_q <= 1'b0;
			rdFromMem_q <= 1'b0;
			rdPtrVal_q <= ebcc_pkg::REG_RESET;
		end else begin
			rdStage_q <= hostReq.rd;
			rdFromMem_q <= expHit;
			rdPtrVal_q <= ptrHit ? bankPointer_q : ebcc_pkg::REG_RESET;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hostRdValid_q <= 1'b0;
			hostRdData_q <= ebcc_pkg::REG_RESET;
		end else begin
			hostRdValid_q <= rdStage_q;
			if (rdStage_q) begin
				hostRdData_q <= rdFromMem_q ? memRdData : rdPtrVal_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit clock held-low detect, one counter per channel
	genvar gc;
	generate
		for (gc = 0; gc < ebcc_pkg::CHANNELS; gc++) begin : gTxClk
			logic [ebcc_pkg::CNT_W-1:0] lowCnt_q;
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					lowCnt_q <= ebcc_pkg::CNT_ZERO;
					txClkHeldLow_q[gc] <= 1'b0;
				end else if (txClockPin[gc]) begin
					lowCnt_q <= ebcc_pkg::CNT_ZERO;
					txClkHeldLow_q[gc] <= 1'b0;
				end else if (lowCnt_q == ebcc_pkg::TX_LOW_LAST) begin
					txClkHeldLow_q[gc] <= 1'b1; // see R10
				end else begin
					lowCnt_q <= lowCnt_q + ebcc_pkg::CNT_ONE;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Per-channel settings; bit n of each register is channel n
	assign forcedSingle = words[ebcc_pkg::OFS_SINGLE_RAIL]
		& ~words[ebcc_pkg::OFS_RECOVERY]; // see R5 see R15
	assign singleRailMode = forcedSingle | (~words[ebcc_pkg::OFS_SINGLE_RAIL] & txNegRailPin);
	assign amiMode = words[ebcc_pkg::OFS_LINE_CODE] & forcedSingle; // see R6

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			chanCfg_q <= '0;
		end else begin
			chanCfg_q.singleRail <= singleRailMode; // see R5
			chanCfg_q.amiCode <= amiMode; // see R6
			chanCfg_q.recoveryOff <= words[ebcc_pkg::OFS_RECOVERY]; // see R7
			chanCfg_q.rxSleep <= words[ebcc_pkg::OFS_RX_SLEEP]; // see R8
			chanCfg_q.txSleep <= words[ebcc_pkg::OFS_TX_SLEEP] | txClkHeldLow_q; // see R9 see R10
			chanCfg_q.zeroDetect <= words[ebcc_pkg::OFS_ZERO_RUN]
				& singleRailMode & ~amiMode; // see R11
			chanCfg_q.violationDetect <= ~words[ebcc_pkg::OFS_VIOLATION]
				& singleRailMode & ~amiMode; // see R12
			chanCfg_q.equalizer <= words[ebcc_pkg::OFS_EQUALIZER]; // see R13
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	// Length of the current store-clear run, for the soft reset checks
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			clearRun_q <= ebcc_pkg::CNT_ZERO;
		end else if (memClear) begin
			clearRun_q <= clearRun_q + ebcc_pkg::CNT_ONE;
		end else begin
			clearRun_q <= ebcc_pkg::CNT_ZERO;
		end
	end

	sequence ptrWriteSeq;
		hostReq.wr && ptrHit && !memClear;
	endsequence

	sequence softStartSeq;
		state_q == ebcc_pkg::EBCC_RUN && hostReq.wr && softRstHit;
	endsequence

	sequence clearEndSeq;
		memClear ##1 !memClear;
	endsequence

	property ptrLoadP;
		logic [ebcc_pkg::DATA_W-1:0] v;
		@(posedge clk) disable iff (!nrst)
		(ptrWriteSeq, v = hostReq.data) |=> bankPointer_q == v;
	endproperty

	ptr_load_a: assert property (ptrLoadP) // see R1
		else $error("bank pointer did not take written value");

	bank_select_a: assert property (@(posedge clk) disable iff (!nrst) // see R3
		expandedSel_q == (bankPointer_q == ebcc_pkg::BANK_EXPANDED))
		else $error("bank select disagrees with pointer");

	primary_default_a: assert property (@(posedge clk) // see R4
		$rose(nrst) |-> bankPointer_q == ebcc_pkg::BANK_PRIMARY && !expandedSel_q)
		else $error("pointer not primary after reset");

	reset_clear_a: assert property (@(posedge clk) // see R14
		$rose(nrst) |-> words == '0 && chanCfg_q == '0 && !hostRdValid_q)
		else $error("register not cleared by reset");

	soft_reset_start_a: assert property (@(posedge clk) disable iff (!nrst) // see R17
		softStartSeq |=> memClear)
		else $error("soft reset did not start");

	soft_reset_len_a: assert property (@(posedge clk) disable iff (!nrst) // see R17
		clearEndSeq |-> clearRun_q == ebcc_pkg::SOFT_RST_LAST + ebcc_pkg::CNT_ONE)
		else $error("soft reset length wrong");

	soft_reset_cap_a: assert property (@(posedge clk) disable iff (!nrst) // see R17
		memClear |-> clearRun_q < ebcc_pkg::SOFT_RST_LAST + ebcc_pkg::CNT_ONE)
		else $error("soft reset ran too long");

	soft_busy_a: assert property (@(posedge clk) disable iff (!nrst) // see R17
		memClear ##1 memClear |-> softResetBusy_q)
		else $error("busy low during soft reset");

	soft_reset_clear_a: assert property (@(posedge clk) disable iff (!nrst) // see R14
		memClear |=> bankPointer_q == ebcc_pkg::BANK_PRIMARY
			&& words == '0)
		else $error("soft reset left a register set");

	exp_write_a: assert property (@(posedge clk) disable iff (!nrst) // see R15
		memWrEn |=> words[$past(hostReq.addr[ebcc_pkg::IDX_W-1:0])]
			== $past(hostReq.data))
		else $error("expanded write lost");

	exp_read_a: assert property (@(posedge clk) disable iff (!nrst) // see R3
		hostReq.rd && expHit |-> ##2 hostRdData_q
			== $past(words[hostReq.addr[ebcc_pkg::IDX_W-1:0]], 2))
		else $error("expanded read returned wrong data");

	ptr_read_a: assert property (@(posedge clk) disable iff (!nrst) // see R16
		hostReq.rd && ptrHit |-> ##2 hostRdData_q
			== $past(bankPointer_q, 2))
		else $error("pointer read returned wrong data");

	primary_isolated_a: assert property (@(posedge clk) disable iff (!nrst) // see R2
		!expandedSel_q && hostReq.wr && !memClear |=> $stable(words))
		else $error("primary bank write hit expanded store");

	tx_sleep_a: assert property (@(posedge clk) disable iff (!nrst) // see R9
		(words[ebcc_pkg::OFS_TX_SLEEP] != '0) |=>
			(chanCfg_q.txSleep & $past(words[ebcc_pkg::OFS_TX_SLEEP]))
			== $past(words[ebcc_pkg::OFS_TX_SLEEP]))
		else $error("transmitter sleep not applied");

	tx_clk_low_a: assert property (@(posedge clk) disable iff (!nrst) // see R10
		!txClockPin[0] [*8] ##1 !txClockPin[0] [*8] ##1 !txClockPin[0] [*8]
			##1 !txClockPin[0] [*8] ##1 !txClockPin[0] [*8] ##1 !txClockPin[0] [*8]
			##1 !txClockPin[0] [*8] ##1 !txClockPin[0] [*8] ##1 !txClockPin[0]
			|-> ##2 chanCfg_q.txSleep[0])
		else $error("held-low clock did not sleep transmitter");

	tx_clk_release_a: assert property (@(posedge clk) disable iff (!nrst) // see R10
		txClockPin[0] ##1 txClockPin[0] |=> chanCfg_q.txSleep[0]
			== $past(words[ebcc_pkg::OFS_TX_SLEEP][0]))
		else $error("running clock left transmitter asleep");

	code_select_a: assert property (@(posedge clk) disable iff (!nrst) // see R6
		##1 chanCfg_q.amiCode == $past(words[ebcc_pkg::OFS_LINE_CODE]
			& words[ebcc_pkg::OFS_SINGLE_RAIL] & ~words[ebcc_pkg::OFS_RECOVERY]))
		else $error("line code not gated by single rail and recovery");

	single_rail_a: assert property (@(posedge clk) disable iff (!nrst) // see R5
		##1 (chanCfg_q.singleRail & $past(words[ebcc_pkg::OFS_SINGLE_RAIL]
			& ~words[ebcc_pkg::OFS_RECOVERY])) == $past(words[ebcc_pkg::OFS_SINGLE_RAIL]
			& ~words[ebcc_pkg::OFS_RECOVERY]))
		else $error("forced single rail not applied");

	recovery_map_a: assert property (@(posedge clk) disable iff (!nrst) // see R7
		##1 chanCfg_q.recoveryOff == $past(words[ebcc_pkg::OFS_RECOVERY]))
		else $error("recovery setting not applied");

	rx_sleep_map_a: assert property (@(posedge clk) disable iff (!nrst) // see R8
		##1 chanCfg_q.rxSleep == $past(words[ebcc_pkg::OFS_RX_SLEEP]))
		else $error("receiver sleep not applied");

	zero_detect_a: assert property (@(posedge clk) disable iff (!nrst) // see R11
		##1 (chanCfg_q.zeroDetect & ~$past(words[ebcc_pkg::OFS_ZERO_RUN])) == '0)
		else $error("zero-run detect on with enable bit clear");

	violation_pol_a: assert property (@(posedge clk) disable iff (!nrst) // see R12
		##1 (chanCfg_q.violationDetect & $past(words[ebcc_pkg::OFS_VIOLATION])) == '0)
		else $error("violation detect enabled with disable bit set");

	equalizer_map_a: assert property (@(posedge clk) disable iff (!nrst) // see R13
		##1 chanCfg_q.equalizer == $past(words[ebcc_pkg::OFS_EQUALIZER]))
		else $error("equalizer setting not applied");

	read_latency_a: assert property (@(posedge clk) disable iff (!nrst) // see R1
		hostReq.rd ##1 !hostReq.rd |-> ##1 hostRdValid_q ##1 !hostRdValid_q)
		else $error("read answer not two cycles later");
endmodule

/* verification/ebcc_host_model.sv */
// Host processor model driving the register port of the expanded bank block.
// Assumes the bench calls its tasks only after reset has been released.
module ebcc_host_model (
	input wire logic clk,
	input wire logic [7:0] rdData,
	input wire logic rdValid,
	output ebcc_pkg::ebcc_host_req_type hostReq
);
	timeunit 1ns;
	timeprecision 100ps;

	initial hostReq = '0;

	////////////////////////////////////////////////////////////////////////////////
	// One-cycle write strobe, changed just after the edge
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 hostReq = {1'b1, 1'b0, a, d};
		@(posedge clk);
		#1 hostReq = '0;
	endtask

	// Read strobe, then wait a bounded number of edges for the answer
	task automatic rd(input logic [4:0] a, output logic [7:0] d, output int lat);
		lat = 1;
		@(posedge clk);
		#1 hostReq = {1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		#1 hostReq = '0;
		do begin
			@(posedge clk);
			#1;
			lat++;
		end while (rdValid !== 1'b1 && lat < 8);
		d = rdData;
	endtask
endmodule

/* verification/testbench.sv */
// Self-checking bench for the expanded bank channel config block.
// Assumes the host model drives the register port; the bench drives the line pins.
module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [7:0] VALS [8] = '{8'h0f, 8'h05, 8'h03, 8'h11, 8'h22, 8'hff, 8'h30, 8'h81};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] txNegRailPin = 8'hf0;
	logic [7:0] txClockPin = 8'hff;
	ebcc_pkg::ebcc_host_req_type hostReq;
	logic [7:0] hostRdData_q;
	logic [7:0] bankPointer_q;
	logic hostRdValid_q;
	logic expandedSel_q;
	logic softResetBusy_q;
	ebcc_pkg::ebcc_chan_cfg_type chanCfg_q;
	int n_mismatch = 0;
	int n_tests = 0;
	int cycles = 0;
	logic [7:0] regs [8] = '{default: 8'h00};
	logic [7:0] rdv;
	int lat;

	always #5 clk = ~clk;

	ebcc_expanded_bank uut (.clk(clk), .nrst(nrst), .hostReq(hostReq),
		.txNegRailPin(txNegRailPin), .txClockPin(txClockPin), .hostRdData_q(hostRdData_q),
		.hostRdValid_q(hostRdValid_q), .bankPointer_q(bankPointer_q),
		.expandedSel_q(expandedSel_q), .softResetBusy_q(softResetBusy_q), .chanCfg_q(chanCfg_q));

	ebcc_host_model host (.clk(clk), .rdData(hostRdData_q), .rdValid(hostRdValid_q),
		.hostReq(hostReq));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rd_check(input logic [4:0] a, input logic [7:0] exp);
		host.rd(a, rdv, lat);
		check("read data", {56'h0, rdv}, {56'h0, exp});
		check("read latency", lat, 2);
	endtask

	// Channel outputs worked out from the stored settings and pins
	function automatic ebcc_pkg::ebcc_chan_cfg_type exp_cfg(input logic [7:0] clkLow);
		logic [7:0] sr;
		logic [7:0] ami;
		sr = (regs[0] & ~regs[2]) | (~regs[0] & txNegRailPin);
		ami = regs[1] & regs[0] & ~regs[2];
		return {sr, ami, regs[2], regs[3], regs[4] | clkLow, regs[5] & sr & ~ami,
			~regs[6] & sr & ~ami, regs[7]};
	endfunction

	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_reset();
		settle();
		check("pointer", bankPointer_q, 8'h00);
		check("expanded select", expandedSel_q, 1'b0);
		check("chanCfg", chanCfg_q, exp_cfg(8'h00));
		rd_check(5'h1f, 8'h00);
		$display("test reset done");
	endtask

	task automatic test_expanded();
		host.wr(5'h1f, 8'haa);
		settle();
		check("expanded select", expandedSel_q, 1'b1);
		for (int i = 0; i < 8; i++) begin
			regs[i] = VALS[i];
			host.wr(5'(i), regs[i]);
		end
		for (int i = 0; i < 8; i++) begin
			rd_check(5'(i), regs[i]);
		end
		rd_check(5'h1f, 8'haa);
		check("chanCfg", chanCfg_q, exp_cfg(8'h00));
		$display("test expanded done");
	endtask

	task automatic test_clock_low();
		txClockPin[0] = 1'b0;
		repeat (30) @(posedge clk);
		#1;
		check("chanCfg short low", chanCfg_q, exp_cfg(8'h00));
		repeat (40) @(posedge clk);
		#1;
		check("chanCfg held low", chanCfg_q, exp_cfg(8'h01));
		txClockPin[0] = 1'b1;
		settle();
		check("chanCfg clock back", chanCfg_q, exp_cfg(8'h00));
		$display("test clock low done");
	endtask

	task automatic test_primary();
		host.wr(5'h1f, 8'h55);
		settle();
		check("expanded select", expandedSel_q, 1'b0);
		rd_check(5'h1f, 8'h55);
		rd_check(5'h03, 8'h00);
		host.wr(5'h03, 8'hff);
		settle();
		check("chanCfg", chanCfg_q, exp_cfg(8'h00));
		$display("test primary done");
	endtask

	task automatic test_soft_reset();
		int n;
		host.wr(ebcc_pkg::SOFT_RST_ADDR, 8'h00);
		check("busy", softResetBusy_q, 1'b1);
		host.wr(5'h1f, 8'haa);
		n = 3;
		while (softResetBusy_q === 1'b1 && n < 300) begin
			@(posedge clk);
			#1;
			if (softResetBusy_q === 1'b1) n++;
		end
		check("busy cycles", n, 100);
		check("pointer", bankPointer_q, 8'h00);
		regs = '{default: 8'h00};
		host.wr(5'h1f, 8'haa);
		for (int i = 0; i < 8; i++) begin
			rd_check(5'(i), 8'h00);
		end
		check("chanCfg", chanCfg_q, exp_cfg(8'h00));
		host.wr(5'h1f, 8'h00);
		settle();
		check("expanded select", expandedSel_q, 1'b0);
		$display("test soft reset done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Hang guard, well above the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			n_mismatch++;
			final_report();
		end
	end

	initial begin
		repeat (16) @(posedge clk);
		#1 nrst = 1'b1;
		test_reset();
		test_expanded();
		test_clock_low();
		test_primary();
		test_soft_reset();
		final_report();
	end
endmodule
